// ==== design/ssp_pkg.sv ====
// Package for the synchronous serial port I2C control block
package ssp_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] ADDR_STATUS  = 4'h0;
  localparam logic [3:0] ADDR_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_BUFFER  = 4'h2;
  localparam logic [3:0] ADDR_RELOAD  = 4'h3;
  localparam logic [3:0] ADDR_IRQ_ST  = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MSK = 4'h5;
  localparam logic [3:0] ADDR_PINS    = 4'h6;

  // Status register field positions
  localparam int ST_BUF_FULL     = 0;
  localparam int ST_UPD_ADDR     = 1;
  localparam int ST_START        = 3;
  localparam int ST_STOP         = 4;
  localparam int ST_SAMPLE_PHASE = 7;
  // Control register field positions
  localparam int CT_CLK_REL  = 4;
  localparam int CT_EN       = 5;
  localparam int CT_OV       = 6;
  localparam int CT_WR_COLL  = 7;

  // Reset values
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  localparam logic [15:0] RST_RELOAD  = 16'h0000;
  localparam logic [7:0]  RST_MASK    = 8'h00;

  // Mode select codes
  localparam logic [3:0] MODE_SLV10_SP = 4'hf;
  localparam logic [3:0] MODE_SLV7_SP  = 4'he;
  localparam logic [3:0] MODE_FW_MST   = 4'hb;
  localparam logic [3:0] MODE_MST      = 4'h8;
  localparam logic [3:0] MODE_SLV10    = 4'h7;
  localparam logic [3:0] MODE_SLV7     = 4'h6;

  // Interrupt status bit positions
  localparam int IRQ_WR_COLL = 0;
  localparam int IRQ_OV    = 1;
  localparam int IRQ_START = 2;
  localparam int IRQ_STOP  = 3;

  // Decoded mode
  typedef enum logic [4:0] {
    OP_IDLE  = 5'b00001,
    OP_SLAVE = 5'b00010,
    OP_MST   = 5'b00100,
    OP_FWMST = 5'b01000,
    OP_RSVD  = 5'b10000
  } ssp_op_type;

  // Register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ssp_req_type;

endpackage : ssp_pkg

// ==== design/ssp_i2c_ctrl.sv ====
// Control and status logic of the synchronous serial port in I2C modes
`timescale 1ns/100ps
module ssp_i2c_ctrl (
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             scl_oe_o,
  output logic             sda_oe_o,
  output logic             port_sel_o,
  input  wire logic        rx_byte_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        tx_busy_i,
  input  wire logic        tx_active_i,
  input  wire logic        sda_drive_i,
  output logic [7:0]       tx_data_o,
  output logic             tx_load_o,
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // Request carrier and synchronisers
  ssp_pkg::ssp_req_type req;
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  logic [1:0] scl_meta;
  logic [1:0] sda_meta;
  logic       scl_s;
  logic       sda_s;
  logic       sda_d;

  // Two flops per pin; only the second stage is read
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
      sda_d    <= 1'b1;
    end
    else
    begin
      scl_meta <= {scl_meta[0], scl_i};
      sda_meta <= {sda_meta[0], sda_i};
      sda_d    <= sda_meta[1];
    end
  end
  assign scl_s = scl_meta[1];
  assign sda_s = sda_meta[1];

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]  control;
  logic [15:0] reload;
  logic [7:0]  rx_buf;
  logic        buf_full;
  logic        sample_phase_sel;
  logic        stop_seen;
  logic        start_seen;
  logic [7:0]  irq_st;
  logic [7:0]  irq_mask;

  // Register decode
  wire wr_status = req.wr && req.addr == ssp_pkg::ADDR_STATUS;
  wire wr_ctrl   = req.wr && req.addr == ssp_pkg::ADDR_CONTROL;
  wire wr_buf    = req.wr && req.addr == ssp_pkg::ADDR_BUFFER;
  wire wr_rel    = req.wr && req.addr == ssp_pkg::ADDR_RELOAD;
  wire wr_msk    = req.wr && req.addr == ssp_pkg::ADDR_IRQ_MSK;
  wire rd_buf    = req.rd && req.addr == ssp_pkg::ADDR_BUFFER;
  wire rd_irq    = req.rd && req.addr == ssp_pkg::ADDR_IRQ_ST;

  wire       enable  = control[ssp_pkg::CT_EN];
  wire       clock_release = control[ssp_pkg::CT_CLK_REL];
  wire [3:0] mode    = control[3:0];

  // Mode decode
  function automatic ssp_pkg::ssp_op_type decode_mode(input logic [3:0] m,
                                                     input logic en);
    if (!en)
      return ssp_pkg::OP_IDLE;
    case (m)
      ssp_pkg::MODE_SLV10_SP,
      ssp_pkg::MODE_SLV7_SP,
      ssp_pkg::MODE_SLV10,
      ssp_pkg::MODE_SLV7:  return ssp_pkg::OP_SLAVE;
      ssp_pkg::MODE_MST:    return ssp_pkg::OP_MST;
      ssp_pkg::MODE_FW_MST: return ssp_pkg::OP_FWMST;
      default:              return ssp_pkg::OP_RSVD;
    endcase
  endfunction : decode_mode

  ssp_pkg::ssp_op_type op;
  assign op = decode_mode(mode, enable);
  wire is_slave  = op == ssp_pkg::OP_SLAVE;
  wire is_master = op == ssp_pkg::OP_MST;
  // Start/stop interrupts only for the codes with bit 3 set
  wire sp_irq_en = is_slave && mode[3];

  // Bus condition detection
  wire start_det = enable && scl_s && sda_d && !sda_s;
  wire stop_det  = enable && scl_s && !sda_d && sda_s;
  wire bus_busy  = start_seen && !stop_seen;

  // Collision: master needs an idle bus, slave needs shifter done
  wire wr_coll_ev = wr_buf && enable &&
                    ((is_master && (bus_busy || tx_busy_i)) ||
                     (is_slave && tx_busy_i));
  // Overflow counts only while receiving
  wire ov_ev   = rx_byte_i && buf_full && !tx_active_i;

  // Control register; set beats software clear
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
      control <= ssp_pkg::RST_CONTROL[7:0];
    else
    begin
      if (wr_ctrl)
        control <= wdata_i[7:0];
      if (wr_coll_ev)
        control[ssp_pkg::CT_WR_COLL] <= 1'b1;
      if (ov_ev)
        control[ssp_pkg::CT_OV] <= 1'b1;
    end
  end

  // Status, receive buffer and bus flags
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      rx_buf     <= 8'h00;
      buf_full   <= 1'b0;
      sample_phase_sel <= 1'b0;
      stop_seen  <= 1'b0;
      start_seen <= 1'b0;
      reload     <= ssp_pkg::RST_RELOAD;
    end
    else
    begin
      if (wr_status)
        sample_phase_sel <= wdata_i[ssp_pkg::ST_SAMPLE_PHASE];
      if (wr_rel)
        reload <= wdata_i;
      // Keep old byte on overflow, new byte is lost
      if (rx_byte_i && !buf_full)
        rx_buf <= rx_data_i;
      if (rx_byte_i && !buf_full)
        buf_full <= 1'b1;
      else if (rd_buf)
        buf_full <= 1'b0;
      if (!enable)
      begin
        stop_seen  <= 1'b0;
        start_seen <= 1'b0;
      end
      else if (start_det)
      begin
        start_seen <= 1'b1;
        stop_seen  <= 1'b0;
      end
      else if (stop_det)
      begin
        stop_seen  <= 1'b1;
        start_seen <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status, cleared by reading it; new events win
  wire [7:0] irq_ev = {4'h0,
                       stop_det && sp_irq_en,
                       start_det && sp_irq_en,
                       ov_ev,
                       wr_coll_ev};

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      irq_st   <= 8'h00;
      irq_mask <= ssp_pkg::RST_MASK;
      irq_o    <= 1'b0;
    end
    else
    begin
      irq_st   <= (rd_irq ? 8'h00 : irq_st) | irq_ev;
      if (wr_msk)
        irq_mask <= wdata_i[7:0];
      irq_o    <= |(((rd_irq ? 8'h00 : irq_st) | irq_ev) &
                    (wr_msk ? wdata_i[7:0] : irq_mask));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Master clock generator: Fosc / (2 * (reload + 1))
  logic [15:0] brg_cnt;
  logic        scl_gen;

  // Down-counter reloads on expiry; one half period per expiry
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i || !is_master)
    begin
      brg_cnt <= 16'h0000;
      scl_gen <= 1'b1;
    end
    else if (brg_cnt == 16'h0000)
    begin
      brg_cnt <= reload;
      scl_gen <= !scl_gen;
    end
    else
      brg_cnt <= brg_cnt - 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin control; open drain, so enable means pulling low
  wire next_scl_oe = enable &&
                     ((is_slave && !clock_release) ||
                      (is_master && !scl_gen));
  wire next_sda_oe = enable && (is_master || is_slave) && sda_drive_i;

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      scl_oe_o   <= 1'b0;
      sda_oe_o   <= 1'b0;
      port_sel_o <= 1'b0;
      tx_data_o  <= 8'h00;
      tx_load_o  <= 1'b0;
    end
    else
    begin
      scl_oe_o   <= next_scl_oe;
      sda_oe_o   <= next_sda_oe;
      port_sel_o <= enable;
      tx_load_o  <= wr_buf && enable && !wr_coll_ev;
      if (wr_buf && !wr_coll_ev)
        tx_data_o <= wdata_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, valid the cycle after the strobe
  wire [15:0] status_rd = {8'h00, sample_phase_sel, 2'b00, stop_seen,
                           start_seen, 2'b00, buf_full};
  wire [15:0] rd_mux =
    req.addr == ssp_pkg::ADDR_STATUS  ? status_rd :
    req.addr == ssp_pkg::ADDR_CONTROL ? {8'h00, control} :
    req.addr == ssp_pkg::ADDR_BUFFER  ? {8'h00, rx_buf} :
    req.addr == ssp_pkg::ADDR_RELOAD  ? reload :
    req.addr == ssp_pkg::ADDR_IRQ_ST  ? {8'h00, irq_st} :
    req.addr == ssp_pkg::ADDR_IRQ_MSK ? {8'h00, irq_mask} :
    req.addr == ssp_pkg::ADDR_PINS    ? {14'h0000, sda_s, scl_s} :
    16'h0000;

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
      rdata_o <= 16'h0000;
    else
      rdata_o <= req.rd ? rd_mux : 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  stop_clear_a: assert property (!enable |=> !stop_seen)
    else $error("stop flag not cleared while disabled");
  coll_mst_a: assert property (
    wr_buf && is_master && (bus_busy || tx_busy_i)
    |=> control[ssp_pkg::CT_WR_COLL])
    else $error("master collision not flagged");
  coll_slv_a: assert property (
    wr_buf && is_slave && tx_busy_i && !wr_ctrl
    |=> control[ssp_pkg::CT_WR_COLL])
    else $error("slave collision not flagged");
  ovf_set_a: assert property (
    rx_byte_i && buf_full && !tx_active_i |=> control[ssp_pkg::CT_OV])
    else $error("overflow not flagged");
  pin_take_a: assert property (
    enable |=> port_sel_o)
    else $error("pins not taken");
  pin_free_a: assert property (
    !enable |=> !port_sel_o && !scl_oe_o && !sda_oe_o)
    else $error("pins not released");
  clk_stretch_a: assert property (
    is_slave && !clock_release |=> scl_oe_o)
    else $error("clock not stretched");
  sp_irq_a: assert property (
    is_slave && !mode[3] |=> !$rose(irq_st[ssp_pkg::IRQ_START]))
    else $error("start irq in quiet slave mode");
  brg_half_a: assert property (
    is_master && brg_cnt == 16'h0000
    |=> $changed(scl_gen) && brg_cnt == $past(reload))
    else $error("master half period wrong");
  fw_idle_a: assert property (
    op == ssp_pkg::OP_FWMST |=> !scl_oe_o)
    else $error("firmware master drives clock");

  cov_master_c: cover property (is_master && brg_cnt == 16'h0000);
  cov_coll_c:   cover property (wr_coll_ev);
  cov_ovf_c:    cover property (ov_ev);
  cov_stop_c:   cover property (stop_det && sp_irq_en);

endmodule : ssp_i2c_ctrl

// ==== verif/ssp_bus_peer.sv ====
// Behavioural two-wire peer with pull-ups on both bus lines
`timescale 1ns/100ps
module ssp_bus_peer (
  input  wire logic scl_oe_i,
  input  wire logic sda_oe_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic pull_scl;
  logic pull_sda;

  // Open-drain wires: a released line floats high on its pull-up
  assign scl_o = ~(scl_oe_i | pull_scl);
  assign sda_o = ~(sda_oe_i | pull_sda);

  initial
  begin
    pull_scl = 1'b0;
    pull_sda = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Start: data falls while clock high; long steps outlast the 2-flop sync
  task automatic start_cond();
    pull_sda = 1'b1;
    #80 pull_scl = 1'b1;
    #80;
  endtask : start_cond

  // Stop: data rises while clock high, both lines left released
  task automatic stop_cond();
    pull_sda = 1'b1;
    #80 pull_scl = 1'b0;
    #80 pull_sda = 1'b0;
    #80;
  endtask : stop_cond
endmodule : ssp_bus_peer

// ==== verif/ssp_i2c_ctrl_tb.sv ====
// Self-checking testbench of the serial port I2C control block
`timescale 1ns/100ps
module ssp_i2c_ctrl_tb;
  typedef struct packed {logic [15:0] v; logic [15:0] m;} ssp_exp_type;
  logic        clock_i, rstn_i, wr_i, rd_i, rx_byte_i;
  logic [3:0]  addr_i;
  logic [15:0] wdata_i, rdata_o;
  logic [7:0]  rx_data_i, tx_data_o, last_tx;
  logic        tx_busy_i, tx_active_i, scl_oe_o, sda_oe_o, scl, sda;
  logic        port_sel_o, tx_load_o, irq_o, rd_seen, sda_drive_i;
  int          n_errors, n_compared, n_load, cnt;
  logic [31:0] seed;
  logic [15:0] d, r;
  ssp_exp_type exp_q[$];
  ssp_exp_type e;
  logic [3:0]  modes [4] = '{4'hf, 4'he, 4'h7, 4'h6};

  ssp_i2c_ctrl ssp_i2c_ctrl_i (.clock_i(clock_i), .rstn_i(rstn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .scl_i(scl), .sda_i(sda), .scl_oe_o(scl_oe_o),
    .sda_oe_o(sda_oe_o), .port_sel_o(port_sel_o), .rx_byte_i(rx_byte_i),
    .rx_data_i(rx_data_i), .tx_busy_i(tx_busy_i),
    .tx_active_i(tx_active_i), .sda_drive_i(sda_drive_i),
    .tx_data_o(tx_data_o), .tx_load_o(tx_load_o), .irq_o(irq_o));
  ssp_bus_peer ssp_bus_peer_i (.scl_oe_i(scl_oe_o), .sda_oe_i(sda_oe_o),
    .scl_o(scl), .sda_o(sda));

  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  //////////////////////////////////////////////////////////////////////////
  // Comparison, stimulus helpers and the closing task
  task automatic check(logic [15:0] s, logic [15:0] x, string msg);
    n_compared++;
    if (s !== x)
    begin
      n_errors++;
      $display("[FAIL] %0t %s: got %h want %h", $time, msg, s, x);
    end
  endtask : check
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : rnd
  task automatic wr(logic [3:0] a, logic [15:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr
  // Expected read value is queued before the strobe goes out
  task automatic rd(logic [3:0] a, logic [15:0] v, logic [15:0] m);
    exp_q.push_back('{v, m});
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
  endtask : rd
  task automatic rx(logic [7:0] v);
    @(posedge clock_i);
    rx_byte_i <= 1'b1;
    rx_data_i <= v;
    @(posedge clock_i);
    rx_byte_i <= 1'b0;
  endtask : rx
  task automatic settle(int n);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask : settle
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  // Read data stand only in the cycle after the strobe
  always @(posedge clock_i)
  begin
    rd_seen <= rd_i;
    if (tx_load_o)
    begin
      n_load <= n_load + 1;
      last_tx <= tx_data_o;
    end
  end
  always @(negedge clock_i)
    if (rd_seen)
    begin
      e = exp_q.pop_front();
      check(rdata_o & e.m, e.v & e.m, "read data");
    end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #400000;
    n_errors++;
    final_report();
  end

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {rstn_i, wr_i, rd_i, rx_byte_i, tx_busy_i, tx_active_i, sda_drive_i} = '0;
    {addr_i, wdata_i, rx_data_i, n_load, n_errors, n_compared} = '0;
    seed = 32'h93a0;
    repeat (4) @(posedge clock_i);
    rstn_i <= 1'b1;
    rd(ssp_pkg::ADDR_CONTROL, ssp_pkg::RST_CONTROL, 16'hffff);
    rd(ssp_pkg::ADDR_RELOAD, ssp_pkg::RST_RELOAD, 16'hffff);
    rd(ssp_pkg::ADDR_IRQ_MSK, {8'h00, ssp_pkg::RST_MASK}, 16'hffff);
    rd(4'hf, 16'h0000, 16'hffff);
    $display("test reset done");
    // Slave pins: clock held low until released
    wr(ssp_pkg::ADDR_CONTROL, 16'h0026);
    settle(4);
    check(port_sel_o, 1'b1, "pins taken");
    check(scl_oe_o, 1'b1, "clock stretch");
    wr(ssp_pkg::ADDR_IRQ_MSK, 16'h000c);
    foreach (modes[i])
    begin
      wr(ssp_pkg::ADDR_CONTROL, 16'h0030 | modes[i]);
      settle(4);
      check(scl_oe_o, 1'b0, "clock released");
      rd(ssp_pkg::ADDR_IRQ_ST, 16'h0000, 16'h00ff);
      ssp_bus_peer_i.start_cond();
      ssp_bus_peer_i.stop_cond();
      settle(4);
      check(irq_o, modes[i][3], "start stop irq");
      rd(ssp_pkg::ADDR_IRQ_ST, {12'h0, modes[i][3], modes[i][3], 2'b0},
        16'h000c);
      rd(ssp_pkg::ADDR_STATUS, 16'h0010, 16'h0010);
      wr(ssp_pkg::ADDR_CONTROL, 16'h0010 | modes[i]);
      settle(3);
      check(port_sel_o, 1'b0, "pins released");
      rd(ssp_pkg::ADDR_STATUS, 16'h0000, 16'h0010);
    end
    $display("test modes done");
    // Write collision in slave and master use, then a clean load
    wr(ssp_pkg::ADDR_RELOAD, 16'h0003);
    foreach (modes[i])
    begin
      d = (i < 2) ? 16'h0036 : 16'h0028;
      wr(ssp_pkg::ADDR_CONTROL, d);
      tx_busy_i <= 1'b1;
      cnt = n_load;
      wr(ssp_pkg::ADDR_BUFFER, rnd());
      settle(2);
      check(n_load - cnt, 16'h0, "refused load");
      rd(ssp_pkg::ADDR_CONTROL, 16'h0080, 16'h0080);
      wr(ssp_pkg::ADDR_CONTROL, d);
      rd(ssp_pkg::ADDR_CONTROL, 16'h0000, 16'h0080);
      tx_busy_i <= 1'b0;
      r = rnd();
      wr(ssp_pkg::ADDR_BUFFER, r);
      settle(2);
      check(n_load - cnt, 16'h1, "load pulse");
      check(last_tx, r[7:0], "load data");
    end
    $display("test collision done");
    // Overflow keeps the first byte and raises the masked interrupt
    wr(ssp_pkg::ADDR_CONTROL, 16'h0036);
    wr(ssp_pkg::ADDR_IRQ_MSK, 16'h0002);
    d = rnd();
    rx(d[7:0]);
    rx(~d[7:0]);
    settle(3);
    check(irq_o, 1'b1, "overflow irq");
    rd(ssp_pkg::ADDR_CONTROL, 16'h0040, 16'h0040);
    rd(ssp_pkg::ADDR_BUFFER, {8'h00, d[7:0]}, 16'h00ff);
    rd(ssp_pkg::ADDR_IRQ_ST, 16'h0002, 16'h0002);
    wr(ssp_pkg::ADDR_CONTROL, 16'h0036);
    settle(3);
    check(irq_o, 1'b0, "irq cleared");
    // Inputs move only on the rising edge
    @(posedge clock_i);
    tx_active_i <= 1'b1;
    rx(d[7:0]);
    rx(d[7:0]);
    settle(2);
    rd(ssp_pkg::ADDR_CONTROL, 16'h0000, 16'h0040);
    tx_active_i <= 1'b0;
    // Data pin follows the shifter only while a bus mode owns it
    sda_drive_i <= 1'b1;
    settle(3);
    check(sda_oe_o, 1'b1, "data pin driven");
    wr(ssp_pkg::ADDR_CONTROL, 16'h002b);
    settle(3);
    check(scl_oe_o, 1'b0, "firmware master clock");
    check(port_sel_o, 1'b1, "firmware master pins");
    wr(ssp_pkg::ADDR_CONTROL, 16'h0016);
    settle(3);
    check(sda_oe_o, 1'b0, "data pin freed");
    @(posedge clock_i);
    sda_drive_i <= 1'b0;
    $display("test overflow done");
    // Master clock half period is reload plus one cycles
    repeat (3)
    begin
      r = 16'h0003 + (rnd() & 16'h0007);
      wr(ssp_pkg::ADDR_RELOAD, r);
      wr(ssp_pkg::ADDR_CONTROL, 16'h0028);
      for (int k = 0; k < 2; k++)
      begin
        cnt = 0;
        // Sample pins only where they are settled
        settle(0);
        d[0] = scl_oe_o;
        while (scl_oe_o === d[0] && cnt < 100)
        begin
          settle(0);
          cnt++;
        end
        d[0] = scl_oe_o;
        cnt = 0;
        while (scl_oe_o === d[0] && cnt < 100)
        begin
          settle(0);
          cnt++;
        end
      end
      check(cnt, r + 16'h1, "half period");
    end
    $display("test master clock done");
    final_report();
  end
endmodule : ssp_i2c_ctrl_tb
